// *** logic/power_control_register.sv ***
// Power control register with AXI4-Lite access, status flags and interrupt.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "power_ctrl_params.svh"
module power_control_register import power_ctrl_pkg::*; (
  input  wire logic        aclk,             // System clock.
  input  wire logic        aresetn,          // Synchronous reset, active low.
  input  wire logic [7:0]  awaddr,           // Write address.
  input  wire logic        awvalid,          // Write address valid.
  output logic             awready,          // Write address ready.
  input  wire logic [31:0] wdata,            // Write data.
  input  wire logic [3:0]  wstrb,            // Write byte strobes.
  input  wire logic        wvalid,           // Write data valid.
  output logic             wready,           // Write data ready.
  output axi_resp_t        bresp,            // Write response.
  output logic             bvalid,           // Write response valid.
  input  wire logic        bready,           // Write response ready.
  input  wire logic [7:0]  araddr,           // Read address.
  input  wire logic        arvalid,          // Read address valid.
  output logic             arready,          // Read address ready.
  output logic [31:0]      rdata,            // Read data.
  output axi_resp_t        rresp,            // Read response.
  output logic             rvalid,           // Read data valid.
  input  wire logic        rready,           // Read data ready.
  input  wire logic        standby_wake,     // Pulse: chip woke from standby.
  input  wire logic        standby_entered,  // Pulse: chip entered standby.
  input  wire logic        battery_entered,  // Pulse: chip ran from battery.
  input  wire logic        deep_sleep_req,   // CPU deep-sleep request level.
  input  wire logic        wakeup_pin,       // Asynchronous wakeup pin.
  input  wire logic        rtc_alarm,        // Asynchronous RTC alarm level.
  input  wire logic        supply_low,       // Asynchronous comparator: supply below threshold.
  output logic             voltage_monitor_enable, // Monitor on.
  output logic [3:0]       threshold_code,   // Effective 4-bit threshold code.
  output logic [11:0]      threshold_mv,     // Selected threshold in millivolts.
  output logic             backup_write_unlock, // Backup domain writes allowed.
  output lp_mode_t         lp_mode,          // Sampled low-power mode.
  output logic             lp_req,           // Pulse: enter lp_mode now.
  output logic             standby_flag,     // Standby flag.
  output logic             battery_mode_flag, // Battery-mode flag.
  output logic             wakeup_flag,      // Wakeup flag.
  output logic             irq               // Level interrupt.
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic        ext_mode_q;
  logic [2:0]  irq_stat_q, irq_mask_q;
  logic [1:0]  cwk_pipe_q;
  logic [2:0]  s1_q, s2_q, s2_prev_q;
  logic        ds_prev_q, mon_low_q;
  logic        aw_full_q, w_full_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic        wr_go, wr_hit;
  logic [31:0] strb_mask, w1;
  assign wr_go = aw_full_q & w_full_q & ~bvalid;
  assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign w1 = wdata_q & strb_mask;
  always_comb begin
    unique case (waddr_q)
      `OFF_CTRL, `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_MASK, `OFF_EXT_MODE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_full_q <= 1'b1;
        waddr_q <= awaddr;
      end else if (!aw_full_q && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (!w_full_q && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic wr_ctrl, clr_sb, clr_wk;
  assign wr_ctrl = wr_go && waddr_q == `OFF_CTRL;
  assign clr_sb = wr_ctrl && w1[`BIT_CLR_SB];
  assign clr_wk = wr_ctrl && w1[`BIT_CLR_WAKE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST;
    end else if (standby_wake) begin
      ctrl_q <= `CTRL_RST; // R1
    end else if (wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~(`CTRL_WR_MASK & strb_mask)) | (w1 & `CTRL_WR_MASK); // R10 R11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_mode_q <= 1'b0;
      irq_mask_q <= 3'h0;
    end else if (wr_go && wstrb_q[0]) begin
      if (waddr_q == `OFF_EXT_MODE) begin
        ext_mode_q <= wdata_q[0];
      end
      if (waddr_q == `OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_q[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Threshold, monitor and backup outputs
  // ----------------------------------------------------------------
  logic [3:0]  thr_code;
  logic [11:0] thr_mv;
  assign thr_code = {ctrl_q[`BIT_THR_EXT] & ext_mode_q, ctrl_q[`FLD_THR_LO]}; // R3 R6
  always_comb begin
    unique case (thr_code[3:2])
      2'b11: thr_mv = `MV_BASE_EXT_HI + `MV_STEP * {10'h000, thr_code[1:0]}; // R5
      2'b10: thr_mv = `MV_BASE_EXT_LO + `MV_STEP * {10'h000, thr_code[1:0]}; // R5
      default: thr_mv = `MV_BASE_LOW + `MV_STEP * {9'h000, thr_code[2:0]}; // R4
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_code <= 4'h0;
      threshold_mv <= `MV_BASE_LOW;
      voltage_monitor_enable <= 1'b0;
      backup_write_unlock <= 1'b0;
    end else begin
      threshold_code <= thr_code;
      threshold_mv <= thr_mv;
      voltage_monitor_enable <= ctrl_q[`BIT_MON_EN]; // R9
      backup_write_unlock <= ctrl_q[`BIT_UNLOCK]; // R7
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and event detection
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s2_prev_q <= 3'h0;
      ds_prev_q <= 1'b0;
      mon_low_q <= 1'b0;
    end else begin
      s1_q <= {supply_low, rtc_alarm, wakeup_pin};
      s2_q <= s1_q;
      s2_prev_q <= s2_q;
      ds_prev_q <= deep_sleep_req;
      mon_low_q <= ctrl_q[`BIT_MON_EN] & s2_q[2];
    end
  end

  logic wake_set, ds_rise, mon_rise;
  assign wake_set = (s2_q[0] & ~s2_prev_q[0]) | (s2_q[1] & ~s2_prev_q[1]);
  assign ds_rise = deep_sleep_req & ~ds_prev_q;
  assign mon_rise = ctrl_q[`BIT_MON_EN] & s2_q[2] & ~mon_low_q;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A set in the same cycle as its clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cwk_pipe_q <= 2'b00;
      standby_flag <= 1'b0;
      battery_mode_flag <= 1'b0;
      wakeup_flag <= 1'b0;
    end else begin
      cwk_pipe_q <= {cwk_pipe_q[0], clr_wk}; // R11
      if (standby_entered) begin
        standby_flag <= 1'b1;
      end else if (clr_sb) begin
        standby_flag <= 1'b0; // R10
      end
      if (battery_entered) begin
        battery_mode_flag <= 1'b1;
      end else if (clr_sb) begin
        battery_mode_flag <= 1'b0; // R10
      end
      if (wake_set) begin
        wakeup_flag <= 1'b1; // R15
      end else if (cwk_pipe_q[`CLR_WAKE_DLY-1]) begin
        wakeup_flag <= 1'b0; // R11
      end
    end
  end

  // ----------------------------------------------------------------
  // Deep-sleep mode sampling
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_mode <= LP_NONE;
      lp_req <= 1'b0;
    end else begin
      lp_req <= ds_rise; // R16
      if (ds_rise) begin
        if (ctrl_q[`BIT_PD_SEL]) begin
          lp_mode <= LP_STANDBY; // R12
        end else if (ctrl_q[`BIT_REG_LP]) begin
          lp_mode <= LP_STOP_REG_LOW; // R13
        end else begin
          lp_mode <= LP_STOP_REG_ON; // R13
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic [2:0] irq_ev, irq_w1c;
  assign irq_ev = {ds_rise, mon_rise, wake_set};
  assign irq_w1c = (wr_go && waddr_q == `OFF_IRQ_STAT) ? w1[2:0] : 3'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      `OFF_CTRL: rd_mux = ctrl_q; // R10 R11
      `OFF_STATUS: rd_mux = {28'h0, battery_mode_flag, mon_low_q, standby_flag, wakeup_flag};
      `OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      `OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
      `OFF_EXT_MODE: rd_mux = {31'h0, ext_mode_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The unlock output trails the control word by one cycle, so it is checked one cycle on.
  property p_r1;
    standby_wake |=> ctrl_q == `CTRL_RST ##1 backup_write_unlock;
  endproperty
  a_r1: assert property (p_r1) else $error("control not restored after standby wake"); // R1
  property p_r3;
    !ext_mode_q |=> !threshold_code[3];
  endproperty
  a_r3: assert property (p_r3) else $error("extension bit used outside extended mode"); // R3
  property p_r4;
    !threshold_code[3] |-> threshold_mv == `MV_BASE_LOW + `MV_STEP * threshold_code;
  endproperty
  a_r4: assert property (p_r4) else $error("wrong low threshold"); // R4
  property p_r5;
    threshold_code[3] |-> threshold_mv == (threshold_code[2] ? `MV_BASE_EXT_HI : `MV_BASE_EXT_LO)
      + `MV_STEP * threshold_code[1:0];
  endproperty
  a_r5: assert property (p_r5) else $error("wrong extended threshold"); // R5
  property p_r6;
    1'b1 |=> threshold_code[2:0] == $past(ctrl_q[7:5]);
  endproperty
  a_r6: assert property (p_r6) else $error("threshold low bits mismatch"); // R6
  property p_r7;
    $rose(ctrl_q[`BIT_UNLOCK]) |=> $rose(backup_write_unlock);
  endproperty
  a_r7: assert property (p_r7) else $error("backup unlock not following"); // R7
  property p_r9;
    ctrl_q[`BIT_MON_EN] |=> voltage_monitor_enable;
  endproperty
  a_r9: assert property (p_r9) else $error("monitor enable not following"); // R9
  property p_r10;
    clr_sb && !standby_entered |=> !standby_flag && ctrl_q[3:2] == 2'b00;
  endproperty
  a_r10: assert property (p_r10) else $error("standby flag not cleared"); // R10
  property p_r11;
    clr_wk ##1 !wake_set [*2] |=> !wakeup_flag;
  endproperty
  a_r11: assert property (p_r11) else $error("wakeup flag not cleared two cycles on"); // R11
  property p_r11_early;
    clr_wk && wakeup_flag |=> wakeup_flag ##1 wakeup_flag;
  endproperty
  a_r11_early: assert property (p_r11_early) else $error("wakeup flag cleared early"); // R11
  property p_r12;
    ds_rise && ctrl_q[`BIT_PD_SEL] |=> lp_req && lp_mode == LP_STANDBY;
  endproperty
  a_r12: assert property (p_r12) else $error("standby not chosen"); // R12
  property p_r13;
    ds_rise && !ctrl_q[`BIT_PD_SEL] |=> lp_req
      && lp_mode == ($past(ctrl_q[0]) ? LP_STOP_REG_LOW : LP_STOP_REG_ON);
  endproperty
  a_r13: assert property (p_r13) else $error("stop regulator state wrong"); // R13
  property p_r15;
    wake_set |=> wakeup_flag && irq_stat_q[`IRQ_WAKE];
  endproperty
  a_r15: assert property (p_r15) else $error("wakeup flag not set"); // R15
  property p_r16;
    lp_req |-> $past(deep_sleep_req) && !$past(deep_sleep_req, 2);
  endproperty
  a_r16: assert property (p_r16) else $error("mode signalled without request"); // R16

  c_wake_clear: cover property (wakeup_flag ##1 clr_wk ##3 !wakeup_flag);
  c_standby: cover property (lp_req && lp_mode == LP_STANDBY);
  c_ext_thr: cover property (threshold_code == 4'hf);
  c_irq: cover property ($rose(irq));
endmodule // power_control_register

// *** logic/power_ctrl_params.svh ***
// Register map, field positions, reset values and timing counts of the power control block.
// Behaviour
// R1: The control register resets to 0x0000_0700 and returns to that value on wakeup from standby.
// R2: Software keeps the reserved bits 31 to 10 of the control register at their reset value.
// R3: Bit 9 extends the threshold code only while the extended mode bit is 1, which is set first.
// R4: With bit 9 at 0, codes 0000 to 0111 pick 2.2 V to 2.9 V in 0.1 V steps.
// R5: With bit 9 at 1, codes 1000 to 1011 pick 1.78 V to 2.08 V and 1100 to 1111 pick 3.28 V to 3.58 V.
// R6: Bits 7 to 5 give the low three bits of the threshold code and bit 9 its top bit.
// R7: Bit 8 at 1 lets writes reach the RTC and backup domain, at 0 it blocks them.
// R8: Software keeps bit 8 at 1 while the RTC runs from the fast external clock divided by 128.
// R9: Bit 4 switches the supply voltage monitor on at 1 and off at 0.
// R10: Bit 3 reads 0 and a 1 written to it clears the standby and battery-mode flags.
// R11: Bit 2 reads 0 and a 1 written to it clears the wakeup flag two clock cycles later.
// R12: Bit 1 at 1 picks standby on deep sleep, at 0 stop mode with the regulator set by bit 0.
// R13: In stop mode bit 0 at 0 keeps the regulator fully on and at 1 puts it in low power.
// R14: For the deeper stop variant software sets deep sleep and its variant bit and clears bits 1 and 0.
// R15: A wakeup pin rising edge or an RTC alarm sets the wakeup flag, cleared only by reset or bit 2.
// R16: The low-power mode is sampled from bits 1 and 0 when deep sleep is requested, and signalled.
`ifndef POWER_CTRL_PARAMS_SVH
`define POWER_CTRL_PARAMS_SVH
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_IRQ_STAT   8'h08
`define OFF_IRQ_MASK   8'h0c
`define OFF_EXT_MODE   8'h10
`define CTRL_RST       32'h0000_0700
`define CTRL_WR_MASK   32'h0000_03f3
`define BIT_REG_LP     0
`define BIT_PD_SEL     1
`define BIT_CLR_WAKE   2
`define BIT_CLR_SB     3
`define BIT_MON_EN     4
`define FLD_THR_LO     7:5
`define BIT_UNLOCK     8
`define BIT_THR_EXT    9
`define CLR_WAKE_DLY   2
`define MV_BASE_LOW    12'd2200
`define MV_BASE_EXT_LO 12'd1780
`define MV_BASE_EXT_HI 12'd3280
`define MV_STEP        12'd100
`define IRQ_WAKE       0
`define IRQ_MON        1
`define IRQ_LP         2
`endif

// *** logic/power_ctrl_pkg.sv ***
// Types shared by the power control block.
package power_ctrl_pkg;
  typedef enum logic [1:0] {LP_NONE, LP_STOP_REG_ON, LP_STOP_REG_LOW, LP_STANDBY} lp_mode_t;
  typedef logic [1:0] axi_resp_t;
  localparam axi_resp_t RESP_OKAY = 2'h0;
  localparam axi_resp_t RESP_SLVERR = 2'h2;
endpackage

// *** verif/test_power_control_register.sv ***
// Self-checking testbench of the power control register block.
`timescale 1ns/1ps
module test_power_control_register import power_ctrl_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, threshold_code;
  logic [11:0] threshold_mv;
  logic        awready, wready, bvalid, arready, rvalid, lp_req, irq;
  logic        standby_wake, standby_entered, battery_entered, deep_sleep_req;
  logic        wakeup_pin, rtc_alarm, supply_low, voltage_monitor_enable;
  logic        backup_write_unlock, standby_flag, battery_mode_flag, wakeup_flag;
  axi_resp_t   bresp, rresp, rs;
  lp_mode_t    lp_mode;
  int          failures, total_checks, cycles;

  typedef struct {
    logic        ext;
    logic [31:0] d;
    logic [31:0] rb;
    logic [3:0]  code;
    logic [11:0] mv;
    logic        mon;
    logic        unl;
    lp_mode_t    lp;
  } row_t;

  row_t rows [8] = '{
    '{1'b0, 32'h0000_0000, 32'h0000_0400, 4'h0, 12'd2200, 1'b0, 1'b0, LP_STOP_REG_ON},
    '{1'b0, 32'h0000_00f1, 32'h0000_04f1, 4'h7, 12'd2900, 1'b1, 1'b0, LP_STOP_REG_LOW},
    '{1'b0, 32'h0000_03f2, 32'h0000_07f2, 4'h7, 12'd2900, 1'b1, 1'b1, LP_STANDBY},
    '{1'b1, 32'h0000_0203, 32'h0000_0603, 4'h8, 12'd1780, 1'b0, 1'b0, LP_STANDBY},
    '{1'b1, 32'h0000_0260, 32'h0000_0660, 4'hb, 12'd2080, 1'b0, 1'b0, LP_STOP_REG_ON},
    '{1'b1, 32'h0000_0290, 32'h0000_0690, 4'hc, 12'd3280, 1'b1, 1'b0, LP_STOP_REG_ON},
    '{1'b1, 32'h0000_03e1, 32'h0000_07e1, 4'hf, 12'd3580, 1'b0, 1'b1, LP_STOP_REG_LOW},
    '{1'b0, 32'hffff_f1ac, 32'h0000_05a0, 4'h5, 12'd2700, 1'b0, 1'b1, LP_STOP_REG_ON}
  };

  power_control_register i_power_control_register (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .standby_wake, .standby_entered, .battery_entered, .deep_sleep_req,
    .wakeup_pin, .rtc_alarm, .supply_low, .voltage_monitor_enable, .threshold_code,
    .threshold_mv, .backup_write_unlock, .lp_mode, .lp_req, .standby_flag,
    .battery_mode_flag, .wakeup_flag, .irq
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Address and data are released each on its own handshake edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output axi_resp_t r);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output axi_resp_t r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Raises the deep-sleep request and expects exactly one lp_req pulse.
  task automatic sleep_check(input lp_mode_t m);
    int k;
    k = 0;
    @(posedge aclk);
    deep_sleep_req <= 1'b1;
    repeat (4) begin
      @(posedge aclk);
      #1;
      if (lp_req === 1'b1) k++;
    end
    check("lp_req", k, 1);
    check("lp_mode", lp_mode, m);
    deep_sleep_req <= 1'b0;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {standby_wake, standby_entered, battery_entered, deep_sleep_req} = '0;
    {wakeup_pin, rtc_alarm, supply_low} = '0;
    failures = 0;
    total_checks = 0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    foreach (rows[i]) begin
      axi_wr(8'h10, {31'h0, rows[i].ext}, rs);
      axi_wr(8'h00, rows[i].d, rs);
      check("bresp", rs, RESP_OKAY);
      axi_rd(8'h00, rd, rs);
      tick(1);
      check("ctrl", rd, rows[i].rb);
      check("code", threshold_code, rows[i].code);
      check("mv", threshold_mv, rows[i].mv);
      check("mon", voltage_monitor_enable, rows[i].mon);
      check("unlock", backup_write_unlock, rows[i].unl);
      sleep_check(rows[i].lp);
    end
    // Interrupt: masked, unmasked, then cleared by writing one.
    tick(2);
    check("irq_masked", irq, 1'b0);
    axi_rd(8'h08, rd, rs);
    check("irq_stat", rd, 32'h0000_0004);
    axi_wr(8'h0c, 32'h0000_0004, rs);
    tick(2);
    check("irq_on", irq, 1'b1);
    axi_wr(8'h08, 32'h0000_0004, rs);
    tick(2);
    check("irq_clr", irq, 1'b0);
    // Wakeup flag: set by pin, cleared two cycles after the write.
    wakeup_pin <= 1'b1;
    tick(5);
    check("wake_pin", wakeup_flag, 1'b1);
    axi_wr(8'h00, 32'h0000_0004, rs);
    #1;
    check("wake_hold", wakeup_flag, 1'b1);
    tick(1);
    check("wake_clr", wakeup_flag, 1'b0);
    wakeup_pin <= 1'b0;
    rtc_alarm <= 1'b1;
    tick(5);
    check("wake_alarm", wakeup_flag, 1'b1);
    axi_wr(8'h00, 32'h0000_0000, rs);
    tick(3);
    check("wake_keep", wakeup_flag, 1'b1);
    rtc_alarm <= 1'b0;
    // Standby and battery flags with the supply monitor running.
    standby_entered <= 1'b1;
    battery_entered <= 1'b1;
    tick(1);
    standby_entered <= 1'b0;
    battery_entered <= 1'b0;
    axi_wr(8'h00, 32'h0000_0110, rs);
    supply_low <= 1'b1;
    tick(5);
    axi_rd(8'h04, rd, rs);
    check("status_set", rd, 32'h0000_000f);
    supply_low <= 1'b0;
    axi_wr(8'h00, 32'h0000_0008, rs);
    tick(3);
    axi_rd(8'h04, rd, rs);
    check("status_clr", rd, 32'h0000_0001);
    check("sb_port", standby_flag, 1'b0);
    check("bat_port", battery_mode_flag, 1'b0);
    // Wake from standby restores the control word only.
    axi_wr(8'h00, 32'h0000_00f3, rs);
    standby_wake <= 1'b1;
    tick(1);
    standby_wake <= 1'b0;
    axi_rd(8'h00, rd, rs);
    check("ctrl_wake", rd, 32'h0000_0700);
    check("wake_sticky", wakeup_flag, 1'b1);
    // Unmapped address.
    axi_wr(8'h20, 32'hffff_ffff, rs);
    check("bresp_bad", rs, RESP_SLVERR);
    axi_rd(8'h20, rd, rs);
    check("rresp_bad", rs, RESP_SLVERR);
    check("rdata_bad", rd, 32'h0000_0000);
    // Reset in mid-run.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    tick(3);
    axi_rd(8'h00, rd, rs);
    check("ctrl_rst", rd, 32'h0000_0700);
    check("code_rst", threshold_code, 4'h0);
    check("mv_rst", threshold_mv, 12'd2200);
    check("unlock_rst", backup_write_unlock, 1'b1);
    check("wake_rst", wakeup_flag, 1'b0);
    check("lp_rst", lp_mode, LP_NONE);
    report_and_stop();
  end
endmodule // test_power_control_register
